// [tb_tccol_timer.sv]
// Purpose: register-level test of tccol_timer
// Assumes: AXI4-Lite master driven at rising edges
// Notes:   bus answers sampled at the falling edge
`timescale 1ns/1ps
`default_nettype none
module tb_tccol_timer;
	import tccol_pkg::*;
	localparam int unsigned NCH = 12;
	logic            aclk;
	logic            aresetn;
	tccol_axi_req_t  req;
	tccol_axi_rsp_t  rsp;
	logic [NCH-1:0]  timer_in;
	logic [NCH-1:0]  timer_out;
	int              error_cnt;
	int              check_count;
	logic [31:0]     rd;
	logic [1:0]      rs;
	logic [31:0]     d0;
	tccol_timer #(.U0_CH(8), .U1_CH(4)) tccol_timer_inst (.aclk(aclk), .aresetn(aresetn), .axi_req(req),
		.axi_rsp(rsp), .timer_in(timer_in), .timer_out(timer_out));
	tccol_pins #(.NCH(NCH)) tccol_pins_inst (.aclk(aclk), .timer_out(timer_out), .timer_in(timer_in));
	initial begin
		aclk = 1'b0;
		forever #2 aclk = ~aclk;
	end
	// ****************
	// reporting
	// ****************
	task automatic test_done();
		$display("checks %0d errors %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			$display("ERROR %s expected %h seen %h", nm, exp, got);
			error_cnt++;
		end
	endtask
	// ****************
	// bus tasks
	// ****************
	task automatic wr(input logic [19:0] a, input logic [31:0] d, input logic [3:0] s);
		int n;
		logic ah;
		logic wh;
		logic bh;
		@(posedge aclk);
		req.awaddr <= {12'h0, a};
		req.wdata <= d;
		req.wstrb <= s;
		req.awvalid <= 1'b1;
		req.wvalid <= 1'b1;
		req.bready <= 1'b1;
		for (n = 0; n < 64; n++) begin
			@(negedge aclk);
			ah = req.awvalid && rsp.awready;
			wh = req.wvalid && rsp.wready;
			bh = req.bready && rsp.bvalid;
			rs = rsp.bresp;
			@(posedge aclk);
			if (ah) req.awvalid <= 1'b0;
			if (wh) req.wvalid <= 1'b0;
			if (bh) begin
				req.bready <= 1'b0;
				break;
			end
		end
		if (n == 64) begin
			error_cnt++;
			test_done();
		end
	endtask
	task automatic rdv(input logic [19:0] a);
		int n;
		logic ah;
		logic rh;
		@(posedge aclk);
		req.araddr <= {12'h0, a};
		req.arvalid <= 1'b1;
		req.rready <= 1'b1;
		for (n = 0; n < 64; n++) begin
			@(negedge aclk);
			ah = req.arvalid && rsp.arready;
			rh = req.rready && rsp.rvalid;
			rd = rsp.rdata;
			rs = rsp.rresp;
			@(posedge aclk);
			if (ah) req.arvalid <= 1'b0;
			if (rh) begin
				req.rready <= 1'b0;
				break;
			end
		end
		if (n == 64) begin
			error_cnt++;
			test_done();
		end
	endtask
	task automatic rchk(input string nm, input logic [19:0] a, input logic [31:0] exp);
		rdv(a);
		chk(nm, rd, exp);
	endtask
	// ****************
	// scenarios
	// ****************
	initial begin
		req = '0;
		aresetn = 1'b0;
		error_cnt = 0;
		check_count = 0;
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		for (int i = 0; i < NCH; i++) rchk("count_rst", OFS_COUNT + 20'(4 * i), 32'hffff);
		rchk("pol0_rst", OFS_POL0, 32'h0);
		rchk("pol1_rst", OFS_POL1, 32'h0);
		rchk("pin_rst", OFS_PIN, 32'h0);
		wr(OFS_POL0, 32'ha5, 4'hf);
		rchk("pol0_word", OFS_POL0, 32'ha5);
		wr(OFS_POL0, 32'h3c, 4'h1);
		rchk("pol0_byte", OFS_POL0, 32'h3c);
		wr(OFS_POL1, 32'hf, 4'hf);
		rchk("pol1_word", OFS_POL1, 32'hf);
		rdv(20'hf0300);
		chk("bad_resp", {30'h0, rs}, {30'h0, RESP_SLVERR});
		wr(OFS_PER_EN, 32'h3, 4'hf);
		for (int i = 0; i < 5; i++) begin
			wr(OFS_MODE + 20'(4 * i), 32'(i), 4'hf);
			rchk("mode_count", OFS_COUNT + 20'(4 * i), (i == 1 || i == 4) ? 32'h0 : 32'hffff);
		end
		// unit enabled and channel 0 idle, so a dropped write is visible
		wr(OFS_COUNT, 32'h1234, 4'hf);
		chk("count_wr_resp", {30'h0, rs}, {30'h0, RESP_OKAY});
		rchk("count_ro", OFS_COUNT, 32'hffff);
		wr(OFS_MODE + 20'h14, 32'h0, 4'hf);
		wr(OFS_DATA + 20'h14, 32'h20, 4'hf);
		wr(OFS_START, 32'h20, 4'hf);
		rdv(OFS_COUNT + 20'h14);
		chk("count_run", {31'h0, rd <= 32'h20}, 32'h1);
		rchk("data_kept", OFS_DATA + 20'h14, 32'h20);
		wr(OFS_STOP, 32'h20, 4'hf);
		rdv(OFS_COUNT + 20'h14);
		d0 = rd;
		repeat (10) @(posedge aclk);
		rchk("stop_value", OFS_COUNT + 20'h14, d0);
		wr(OFS_PER_EN, 32'h2, 4'hf);
		rchk("dis_preset", OFS_COUNT + 20'h14, 32'hffff);
		rchk("dis_capt", OFS_COUNT + 20'h4, 32'hffff);
		wr(OFS_PER_EN, 32'h3, 4'hf);
		wr(OFS_MODE + 20'h4, 32'h1, 4'hf);
		wr(OFS_START, 32'h2, 4'hf);
		repeat (40) @(posedge aclk);
		tccol_pins_inst.pulse(1, 3);
		repeat (4) @(posedge aclk);
		rdv(OFS_DATA + 20'h4);
		d0 = rd;
		rdv(OFS_COUNT + 20'h4);
		chk("capt_clear", {31'h0, rd < d0}, 32'h1);
		// channel 2 master one-count, channel 3 slave one-count, both outputs on
		wr(OFS_MODE + 20'h8, 32'h3, 4'hf);
		wr(OFS_MODE + 20'hc, 32'h3, 4'hf);
		wr(OFS_DATA + 20'h8, 32'h5, 4'hf);
		wr(OFS_DATA + 20'hc, 32'h3, 4'hf);
		wr(OFS_ROLE, 32'h8, 4'hf);
		wr(OFS_OUT_EN, 32'hc, 4'hf);
		wr(OFS_START, 32'hc, 4'hf);
		rchk("one_hold", OFS_COUNT + 20'h8, 32'hffff);
		wr(OFS_START, 32'h4, 4'hf);
		repeat (20) @(posedge aclk);
		rchk("pin_out", OFS_PIN, 32'hc);
		rchk("one_wait", OFS_COUNT + 20'h8, 32'hffff);
		rchk("slave_done", OFS_COUNT + 20'hc, 32'hffff);
		wr(OFS_POL0, 32'h34, 4'hf);
		rchk("pin_pol_hold", OFS_PIN, 32'hc);
		wr(OFS_START, 32'h4, 4'hf);
		repeat (20) @(posedge aclk);
		rchk("pin_pol_next", OFS_PIN, 32'h0);
		// channel 4 capture plus one-count: waits holding capture plus one
		wr(OFS_START, 32'h10, 4'hf);
		wr(OFS_START, 32'h10, 4'hf);
		tccol_pins_inst.pulse(4, 2);
		repeat (4) @(posedge aclk);
		rdv(OFS_DATA + 20'h10);
		d0 = rd;
		rchk("capt_one_wait", OFS_COUNT + 20'h10, d0 + 32'h1);
		test_done();
	end
endmodule
`default_nettype wire

// [tccol_chk_sva.sv]
// Purpose: bus and pin checks of tccol_timer
// Assumes: one clock, synchronous active-low reset
// Notes:   bound at the foot of this file
`timescale 1ns/1ps
`default_nettype none
module tccol_chk
	import tccol_pkg::*;
#(
	parameter int unsigned U0_CH = 8,
	parameter int unsigned U1_CH = 4
) (
	// clock and reset
	input wire logic                      aclk,
	input wire logic                      aresetn,
	// register bus
	input wire tccol_pkg::tccol_axi_req_t axi_req,
	input wire tccol_pkg::tccol_axi_rsp_t axi_rsp,
	// timer pins
	input wire logic [U0_CH+U1_CH-1:0]    timer_in,
	input wire logic [U0_CH+U1_CH-1:0]    timer_out
);
	// ****************
	// last addresses
	// ****************
	logic [19:0] ra_ff;
	logic [19:0] wa_ff;
	logic        rd_cnt;
	logic        rd_pol;
	logic        rd_bad;
	logic        wr_cnt;
	always_ff @(posedge aclk) begin
		if (axi_req.arvalid && axi_rsp.arready) begin
			ra_ff <= axi_req.araddr[19:0];
		end
	end
	always_ff @(posedge aclk) begin
		if (axi_req.awvalid && axi_rsp.awready) begin
			wa_ff <= axi_req.awaddr[19:0];
		end
	end
	assign rd_cnt = ra_ff < OFS_COUNT + 20'(4 * (U0_CH + U1_CH)) && ra_ff >= OFS_COUNT && ra_ff[1:0] == 2'h0;
	assign wr_cnt = wa_ff < OFS_COUNT + 20'(4 * (U0_CH + U1_CH)) && wa_ff >= OFS_COUNT && wa_ff[1:0] == 2'h0;
	assign rd_pol = ra_ff == OFS_POL0 || ra_ff == OFS_POL1;
	assign rd_bad = ra_ff < OFS_COUNT || ra_ff > OFS_POL1 || ra_ff[1:0] != 2'h0;
	// ****************
	// properties
	// ****************
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	rd_answer_a: assert property (axi_req.arvalid && axi_rsp.arready |=> axi_rsp.rvalid)
		else $error("read not answered next cycle");
	rd_hold_a: assert property (axi_rsp.rvalid && !axi_req.rready |=> axi_rsp.rvalid && $stable(axi_rsp.rdata))
		else $error("read data dropped before rready");
	wr_hold_a: assert property (axi_rsp.bvalid && !axi_req.bready |=> axi_rsp.bvalid && $stable(axi_rsp.bresp))
		else $error("write response dropped early");
	wr_answer_a: assert property (axi_req.awvalid && axi_rsp.awready && axi_req.wvalid && axi_rsp.wready
		|-> ##2 axi_rsp.bvalid)
		else $error("write response late");
	busy_refuse_a: assert property (axi_rsp.bvalid |-> !axi_rsp.awready && !axi_rsp.wready)
		else $error("write accepted while response pending");
	cnt_read_a: assert property (axi_rsp.rvalid && rd_cnt
		|-> axi_rsp.rresp == RESP_OKAY && axi_rsp.rdata[31:16] == 16'h0)
		else $error("count read malformed");
	pol_read_a: assert property (axi_rsp.rvalid && rd_pol
		|-> axi_rsp.rresp == RESP_OKAY && axi_rsp.rdata[31:8] == 24'h0)
		else $error("polarity read malformed");
	bad_read_a: assert property (axi_rsp.rvalid && rd_bad
		|-> axi_rsp.rresp == RESP_SLVERR && axi_rsp.rdata == 32'h0)
		else $error("unmapped read not refused");
	cnt_write_a: assert property (axi_rsp.bvalid && wr_cnt |-> axi_rsp.bresp == RESP_OKAY)
		else $error("count write not okay");
	rst_idle_a: assert property ($past(aresetn) == 1'b0
		|-> !axi_rsp.bvalid && !axi_rsp.rvalid && timer_out == '0)
		else $error("outputs not idle after reset");
	cover property (axi_rsp.rvalid && axi_rsp.rresp == RESP_SLVERR);
	cover property (axi_rsp.rvalid && rd_cnt && axi_rsp.rdata[15:0] == 16'hffff);
	cover property (axi_rsp.bvalid && wr_cnt);
	cover property (timer_out != '0);
endmodule
bind tccol_timer tccol_chk #(.U0_CH(U0_CH), .U1_CH(U1_CH)) tccol_chk_inst (.aclk(aclk), .aresetn(aresetn),
	.axi_req(axi_req), .axi_rsp(axi_rsp), .timer_in(timer_in), .timer_out(timer_out));
`default_nettype wire

// [tccol_pins.sv]
// Purpose: pin-side model driving capture inputs
// Assumes: pins synchronous to aclk
// Notes:   pulse length sets how many cycles a pin stays high
`timescale 1ns/1ps
`default_nettype none
module tccol_pins #(
	parameter int unsigned NCH = 12
) (
	// clock
	input wire logic            aclk,
	// timer pins
	input wire logic [NCH-1:0]  timer_out,
	output var logic [NCH-1:0]  timer_in
);
	initial begin
		timer_in = '0;
	end
	// one rising edge on a channel input, held len cycles
	task automatic pulse(input int ch, input int len);
		@(posedge aclk);
		timer_in[ch] <= 1'b1;
		repeat (len) @(posedge aclk);
		timer_in[ch] <= 1'b0;
	endtask
endmodule
`default_nettype wire

// [tccol_pkg.sv]
// Purpose: constants, modes and bus carriers of the timer channel count and output level block
// Assumes: AXI4-Lite with 32-bit data; the low 20 address bits select a register
// Notes:   every register takes one aligned word; unused upper bits read as zero
`default_nettype none
package tccol_pkg;

	// ****************************************************************
	// register offsets (byte addresses, low 20 bits)
	// ****************************************************************
	localparam logic [19:0] OFS_COUNT   = 20'hf0000;
	localparam logic [19:0] OFS_DATA    = 20'hf0040;
	localparam logic [19:0] OFS_MODE    = 20'hf0080;
	localparam logic [19:0] OFS_START   = 20'hf00c0;
	localparam logic [19:0] OFS_STOP    = 20'hf00c4;
	localparam logic [19:0] OFS_RUN     = 20'hf00c8;
	localparam logic [19:0] OFS_OUT_EN  = 20'hf00cc;
	localparam logic [19:0] OFS_ROLE    = 20'hf00d0;
	localparam logic [19:0] OFS_PER_EN  = 20'hf00d4;
	localparam logic [19:0] OFS_PIN     = 20'hf00d8;
	localparam logic [19:0] OFS_POL0    = 20'hf01bc;
	localparam logic [19:0] OFS_POL1    = 20'hf01e4;
	localparam int unsigned ARR_LSB     = 6;

	// ****************************************************************
	// fields and reset values
	// ****************************************************************
	localparam int unsigned MODE_LSB    = 0;
	localparam int unsigned MODE_W      = 3;
	localparam int unsigned PER_EN_U0   = 0;
	localparam int unsigned PER_EN_U1   = 1;
	localparam logic [15:0] CNT_PRESET  = 16'hffff;
	localparam logic [15:0] CNT_CLEAR   = 16'h0000;
	localparam logic [15:0] DATA_RST    = 16'h0000;
	localparam logic [15:0] POL_RST     = 16'h0000;
	localparam logic [1:0]  RESP_OKAY   = 2'h0;
	localparam logic [1:0]  RESP_SLVERR = 2'h2;

	// ****************************************************************
	// modes and bus carriers
	// ****************************************************************
	typedef enum logic [MODE_W-1:0] {
		MODE_INTERVAL,
		MODE_CAPTURE,
		MODE_EVENT,
		MODE_ONE_COUNT,
		MODE_CAPT_ONE
	} tccol_mode_t;

	typedef struct packed {
		logic [31:0] awaddr;
		logic        awvalid;
		logic [31:0] wdata;
		logic [3:0]  wstrb;
		logic        wvalid;
		logic        bready;
		logic [31:0] araddr;
		logic        arvalid;
		logic        rready;
	} tccol_axi_req_t;

	typedef struct packed {
		logic        awready;
		logic        wready;
		logic [1:0]  bresp;
		logic        bvalid;
		logic        arready;
		logic [31:0] rdata;
		logic [1:0]  rresp;
		logic        rvalid;
	} tccol_axi_rsp_t;

endpackage
`default_nettype wire

// [tccol_timer.sv]
// Purpose: per-channel count register and output level logic of a two-unit 16-bit timer
// Assumes: one clock aclk, synchronous active-low reset, pins synchronous to aclk
// Notes:   unit 0 owns channels 0..U0_CH-1, unit 1 the channels above
//
// Behaviour
// (R01) count register readable any time
// (R02) reset presets every count to all ones
// (R03) unit enable cleared presets its counts
// (R04) pwm slave done presets count to ones
// (R05) one-shot master or slave done presets ones
// (R06) capture start trigger clears count
// (R07) capture completion clears count
// (R08) count read has no side effects
// (R09) mode set after reset: down ones, up zero
// (R10) mode change after pause: any value
// (R11) restart after pause resumes stop value
// (R12) one-count wait: ones, or capture plus one
// (R13) started channel holds read value until counting
// (R14) polarity bit: zero high, one inverted
// (R15) polarity acts in slave mode when enabled
// (R16) master mode ignores polarity bit
// (R17) polarity change waits for next transition
// (R18) reset clears both polarity registers
// (R19) polarity word writes and low-byte writes
// (R20) software writes zero to unused polarity bits
// (R21) slave set by master, reset by own
// (R22) count register is read-only
//
// Design decision made here: the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module tccol_timer
	import tccol_pkg::*;
#(
	parameter int unsigned U0_CH = 8,
	parameter int unsigned U1_CH = 4
) (
	// clock and reset
	input  wire logic                  aclk,
	input  wire logic                  aresetn,
	// register bus
	input  wire tccol_pkg::tccol_axi_req_t axi_req,
	output var  tccol_pkg::tccol_axi_rsp_t axi_rsp,
	// timer pins
	input  wire logic [U0_CH+U1_CH-1:0] timer_in,
	output var  logic [U0_CH+U1_CH-1:0] timer_out
);
	import tccol_pkg::*;

	localparam int unsigned NCH = U0_CH + U1_CH;

	if (U0_CH < 1 || U0_CH > 8 || U1_CH < 1 || U1_CH > 4) begin : g_bad_cfg
		$error("tccol_timer: channel counts out of range");
	end

	// ****************************************************************
	// register state
	// ****************************************************************
	logic [1:0]            per_en_ff;
	logic [NCH-1:0]        out_en_ff;
	logic [NCH-1:0]        role_ff;
	logic [NCH-1:0]        pol_ff;
	logic [NCH-1:0][15:0]  cnt_a;
	logic [NCH-1:0][15:0]  data_a;
	logic [NCH-1:0][2:0]   mode_a;
	logic [NCH-1:0]        run_a;
	logic [NCH-1:0]        irq_a;
	logic [NCH-1:0]        sw_start;
	logic [NCH-1:0]        sw_stop;
	logic [NCH-1:0]        data_wr;
	logic [NCH-1:0]        mode_wr;

	// ****************************************************************
	// axi4-lite slave
	// ****************************************************************
	logic        aw_got_ff;
	logic        w_got_ff;
	logic        bvalid_ff;
	logic        rvalid_ff;
	logic [19:0] wa_ff;
	logic [31:0] wd_ff;
	logic [3:0]  ws_ff;
	logic [1:0]  bresp_ff;
	logic [1:0]  rresp_ff;
	logic [31:0] rdata_ff;
	logic        wr_fire;
	logic        wr_ok;
	logic [31:0] wmask;
	logic [31:0] rd_data;
	logic        rd_ok;

	assign axi_rsp.awready = ~aw_got_ff & ~bvalid_ff;
	assign axi_rsp.wready  = ~w_got_ff & ~bvalid_ff;
	assign axi_rsp.bvalid  = bvalid_ff;
	assign axi_rsp.bresp   = bresp_ff;
	assign axi_rsp.arready = ~rvalid_ff;
	assign axi_rsp.rvalid  = rvalid_ff;
	assign axi_rsp.rresp   = rresp_ff;
	assign axi_rsp.rdata   = rdata_ff;

	assign wr_fire = aw_got_ff & w_got_ff & ~bvalid_ff;
	assign wmask   = {{8{ws_ff[3]}}, {8{ws_ff[2]}}, {8{ws_ff[1]}}, {8{ws_ff[0]}}};

	function automatic logic arr_hit(input logic [19:0] a, input logic [19:0] base);
		arr_hit = (a[19:ARR_LSB] == base[19:ARR_LSB]) && (32'(a[5:2]) < NCH) && (a[1:0] == 2'h0);
	endfunction

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_got_ff <= 1'b0;
			wa_ff     <= 20'h00000;
		end else if (wr_fire) begin
			aw_got_ff <= 1'b0;
		end else if (axi_req.awvalid && axi_rsp.awready) begin
			aw_got_ff <= 1'b1;
			wa_ff     <= axi_req.awaddr[19:0];
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_got_ff <= 1'b0;
			wd_ff    <= 32'h00000000;
			ws_ff    <= 4'h0;
		end else if (wr_fire) begin
			w_got_ff <= 1'b0;
		end else if (axi_req.wvalid && axi_rsp.wready) begin
			w_got_ff <= 1'b1;
			wd_ff    <= axi_req.wdata;
			ws_ff    <= axi_req.wstrb;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid_ff <= 1'b0;
			bresp_ff  <= RESP_OKAY;
		end else if (wr_fire) begin
			bvalid_ff <= 1'b1;
			bresp_ff  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
		end else if (axi_req.bready) begin
			bvalid_ff <= 1'b0;
		end
	end

	// writes to the count window are accepted and dropped
	always_comb begin
		wr_ok = arr_hit(wa_ff, OFS_COUNT) || arr_hit(wa_ff, OFS_DATA) || arr_hit(wa_ff, OFS_MODE) ||
			wa_ff == OFS_START || wa_ff == OFS_STOP || wa_ff == OFS_RUN || wa_ff == OFS_OUT_EN ||
			wa_ff == OFS_ROLE || wa_ff == OFS_PER_EN || wa_ff == OFS_PIN || wa_ff == OFS_POL0 ||
			wa_ff == OFS_POL1; // [R22]
	end

	// one-cycle command strobes from the write
	always_comb begin
		sw_start = '0;
		sw_stop  = '0;
		data_wr  = '0;
		mode_wr  = '0;
		if (wr_fire && wa_ff == OFS_START) sw_start = wd_ff[NCH-1:0] & wmask[NCH-1:0];
		if (wr_fire && wa_ff == OFS_STOP) sw_stop = wd_ff[NCH-1:0] & wmask[NCH-1:0];
		for (int k = 0; k < NCH; k++) begin
			if (wr_fire && arr_hit(wa_ff, OFS_DATA) && 32'(wa_ff[5:2]) == k) data_wr[k] = 1'b1;
			if (wr_fire && arr_hit(wa_ff, OFS_MODE) && 32'(wa_ff[5:2]) == k && ws_ff[0]) mode_wr[k] = 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			per_en_ff <= 2'h0;
			out_en_ff <= '0;
			role_ff   <= '0;
		end else if (wr_fire) begin
			if (wa_ff == OFS_PER_EN) per_en_ff <= (per_en_ff & ~wmask[1:0]) | (wd_ff[1:0] & wmask[1:0]);
			if (wa_ff == OFS_OUT_EN) out_en_ff <= (out_en_ff & ~wmask[NCH-1:0]) | (wd_ff[NCH-1:0] & wmask[NCH-1:0]);
			if (wa_ff == OFS_ROLE) role_ff <= (role_ff & ~wmask[NCH-1:0]) | (wd_ff[NCH-1:0] & wmask[NCH-1:0]);
		end
	end

	// polarity registers: only the low byte lane holds bits, so a byte write is the low-byte alias
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pol_ff <= POL_RST[NCH-1:0]; // [R18]
		end else if (wr_fire && ws_ff[0]) begin
			if (wa_ff == OFS_POL0) pol_ff[U0_CH-1:0] <= wd_ff[U0_CH-1:0]; // [R19]
			if (wa_ff == OFS_POL1) pol_ff[NCH-1:U0_CH] <= wd_ff[U1_CH-1:0]; // [R19]
		end
	end

	// read mux: reads are free of side effects
	always_comb begin
		logic [19:0] a;
		logic [3:0]  idx;
		a       = axi_req.araddr[19:0];
		idx     = a[5:2];
		rd_data = 32'h00000000;
		rd_ok   = 1'b1;
		if (arr_hit(a, OFS_COUNT)) rd_data = {16'h0000, cnt_a[idx]}; // [R01] [R08]
		else if (arr_hit(a, OFS_DATA)) rd_data = {16'h0000, data_a[idx]};
		else if (arr_hit(a, OFS_MODE)) rd_data = {29'h0, mode_a[idx]};
		else if (a == OFS_START || a == OFS_STOP) rd_data = 32'h00000000;
		else if (a == OFS_RUN) rd_data = 32'(run_a);
		else if (a == OFS_OUT_EN) rd_data = 32'(out_en_ff);
		else if (a == OFS_ROLE) rd_data = 32'(role_ff);
		else if (a == OFS_PER_EN) rd_data = {30'h0, per_en_ff};
		else if (a == OFS_PIN) rd_data = 32'(timer_out);
		else if (a == OFS_POL0) rd_data = 32'(pol_ff[U0_CH-1:0]);
		else if (a == OFS_POL1) rd_data = 32'(pol_ff[NCH-1:U0_CH]);
		else rd_ok = 1'b0;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_ff <= 1'b0;
			rresp_ff  <= RESP_OKAY;
			rdata_ff  <= 32'h00000000;
		end else if (axi_req.arvalid && axi_rsp.arready) begin
			rvalid_ff <= 1'b1;
			rresp_ff  <= rd_ok ? RESP_OKAY : RESP_SLVERR;
			rdata_ff  <= rd_data;
		end else if (axi_req.rready) begin
			rvalid_ff <= 1'b0;
		end
	end

	// ****************************************************************
	// channels
	// ****************************************************************
	for (genvar g = 0; g < NCH; g++) begin : g_ch
		localparam int BASE = (g < U0_CH) ? 0 : U0_CH;
		localparam int UNIT = (g < U0_CH) ? PER_EN_U0 : PER_EN_U1;
		logic [15:0] cnt_ff;
		logic [15:0] data_ff;
		tccol_mode_t mode_ff;
		tccol_mode_t new_mode;
		logic        run_ff;
		logic        fresh_ff;
		logic        wait_ff;
		logic        irq_ff;
		logic        ti_prev_ff;
		logic        lvl_ff;
		logic        out_ff;
		logic        ti_edge;
		logic        m_irq;
		logic        trig;
		logic        new_lvl;

		assign cnt_a[g]     = cnt_ff;
		assign data_a[g]    = data_ff;
		assign mode_a[g]    = mode_ff;
		assign run_a[g]     = run_ff;
		assign irq_a[g]     = irq_ff;
		assign timer_out[g] = out_ff;
		assign new_mode     = tccol_mode_t'(wd_ff[MODE_LSB +: MODE_W]);
		assign ti_edge      = timer_in[g] & ~ti_prev_ff;
		assign trig         = ti_edge | sw_start[g] | (role_ff[g] & m_irq);

		// the master of a slave is the nearest lower master channel of its unit
		always_comb begin
			logic found;
			found = 1'b0;
			m_irq = 1'b0;
			for (int k = g - 1; k >= BASE; k--) begin
				if (!found && !role_ff[k]) begin
					m_irq = irq_a[k];
					found = 1'b1;
				end
			end
		end

		always_ff @(posedge aclk) begin
			if (!aresetn) ti_prev_ff <= 1'b0;
			else ti_prev_ff <= timer_in[g];
		end

		always_ff @(posedge aclk) begin
			if (!aresetn) begin
				cnt_ff   <= CNT_PRESET; // [R02]
				data_ff  <= DATA_RST;
				mode_ff  <= MODE_INTERVAL;
				run_ff   <= 1'b0;
				fresh_ff <= 1'b1;
				wait_ff  <= 1'b0;
				irq_ff   <= 1'b0;
			end else begin
				irq_ff <= 1'b0;
				if (data_wr[g]) data_ff <= (data_ff & ~wmask[15:0]) | (wd_ff[15:0] & wmask[15:0]);
				if (mode_wr[g]) mode_ff <= new_mode;
				if (!per_en_ff[UNIT]) begin
					cnt_ff   <= CNT_PRESET; // [R03]
					run_ff   <= 1'b0;
					fresh_ff <= 1'b1;
					wait_ff  <= 1'b0;
				end else if (mode_wr[g]) begin
					run_ff   <= 1'b0;
					fresh_ff <= 1'b1;
					wait_ff  <= 1'b0;
					cnt_ff   <= (new_mode == MODE_CAPTURE || new_mode == MODE_CAPT_ONE) ? CNT_CLEAR : CNT_PRESET; // [R09] [R10]
				end else if (sw_stop[g]) begin
					run_ff <= 1'b0; // [R11]
				end else if (!run_ff) begin
					if (sw_start[g]) begin
						run_ff  <= 1'b1; // [R13]
						wait_ff <= fresh_ff && (mode_ff == MODE_ONE_COUNT || mode_ff == MODE_CAPT_ONE);
					end
				end else begin
					unique case (mode_ff)
						MODE_INTERVAL: begin
							if (fresh_ff) begin
								cnt_ff   <= data_ff;
								fresh_ff <= 1'b0;
							end else if (cnt_ff == 16'h0000) begin
								cnt_ff <= data_ff;
								irq_ff <= 1'b1;
							end else begin
								cnt_ff <= cnt_ff - 16'h0001;
							end
						end
						MODE_EVENT: begin
							if (fresh_ff) begin
								cnt_ff   <= data_ff;
								fresh_ff <= 1'b0;
							end else if (ti_edge && cnt_ff == 16'h0000) begin
								cnt_ff <= data_ff;
								irq_ff <= 1'b1;
							end else if (ti_edge) begin
								cnt_ff <= cnt_ff - 16'h0001;
							end
						end
						MODE_CAPTURE: begin
							if (fresh_ff) begin
								cnt_ff   <= CNT_CLEAR; // [R06]
								fresh_ff <= 1'b0;
							end else if (ti_edge) begin
								data_ff <= cnt_ff;
								cnt_ff  <= CNT_CLEAR; // [R07]
								irq_ff  <= 1'b1;
							end else begin
								cnt_ff <= cnt_ff + 16'h0001;
							end
						end
						MODE_ONE_COUNT: begin
							if (wait_ff) begin
								if (trig) begin
									cnt_ff   <= data_ff;
									wait_ff  <= 1'b0;
									fresh_ff <= 1'b0;
								end
							end else if (cnt_ff == 16'h0000) begin
								cnt_ff  <= CNT_PRESET; // [R04] [R05] [R12]
								irq_ff  <= 1'b1;
								wait_ff <= 1'b1;
							end else begin
								cnt_ff <= cnt_ff - 16'h0001;
							end
						end
						MODE_CAPT_ONE: begin
							if (wait_ff) begin
								if (trig) begin
									cnt_ff   <= CNT_CLEAR; // [R06]
									wait_ff  <= 1'b0;
									fresh_ff <= 1'b0;
								end
							end else if (ti_edge) begin
								data_ff <= cnt_ff;
								cnt_ff  <= cnt_ff + 16'h0001; // [R12]
								irq_ff  <= 1'b1;
								wait_ff <= 1'b1;
							end else begin
								cnt_ff <= cnt_ff + 16'h0001;
							end
						end
						default: begin
							run_ff <= 1'b0;
						end
					endcase
				end
			end
		end

		// slave: set by master, reset by own event, own end wins a tie
		assign new_lvl = m_irq & ~irq_ff;

		always_ff @(posedge aclk) begin
			if (!aresetn) begin
				lvl_ff <= 1'b0;
				out_ff <= 1'b0;
			end else if (out_en_ff[g]) begin
				if (role_ff[g]) begin
					if (m_irq || irq_ff) begin
						lvl_ff <= new_lvl; // [R21]
						out_ff <= new_lvl ^ pol_ff[g]; // [R14] [R15] [R17]
					end
				end else if (irq_ff) begin
					lvl_ff <= ~lvl_ff; // [R21]
					out_ff <= ~lvl_ff; // [R16]
				end
			end
		end
	end

endmodule
`default_nettype wire
